/* File: design/free_running_and_interval_timer.sv */
// Timer block: 16-bit free-running counter, 1024 us event, 12-bit interval timer.
// Assumes the timer source arrives as a pin unrelated to i_clk, and a
// register master that never issues read and write together.

// How it works
// - Counting paced by separate source pin
// - 16-bit up counter on 4/6 MHz ticks
// - Low byte read latches high byte
// - Both bytes sampled at low read
// - High byte write loads both halves
// - Periodic event every 1024 microseconds
// - Wrap event on FFFF to zero
// - 12-bit interval value, low read latches
// - Interval high read: held nibble, zeros above
// - 12-bit reload, low then high write
// - Interval request priority 14, vector 38h
// - Wrap request priority 17, vector 44h
// - Posted flags readable, cleared writing zero
module free_running_and_interval_timer
   import frit_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Timer source pin
   input wire logic i_tmr_src,
   // Register port
   input wire bus_req_s i_bus,
   output logic [7:0] o_rdata,
   // Interrupt
   output logic o_irq,
   output irq_req_s o_irq_req
);
   logic src_meta_ff, src_sync_ff, src_last_ff;
   logic [2:0] us_div_ff;
   logic [9:0] us_cnt_ff;
   logic [15:0] free_cnt_ff;
   logic [7:0] free_hold_ff;
   logic [7:0] free_wlow_ff;
   logic [11:0] ivl_cnt_ff;
   logic [3:0] ivl_hold_ff;
   logic [11:0] ivl_rld_ff;
   logic [7:0] ivl_wlow_ff;
   logic [NUM_EV-1:0] flags_ff, en_ff;
   logic [1:0] ctrl_ff;
   logic [7:0] rdata_ff;
   irq_req_s irq_req_ff;

   // Strobe qualified by one register offset
   function automatic logic at_ofs(input logic stb, input logic [7:0] adr, ofs);
      return stb && adr == ofs;
   endfunction

   // Decode
   wire wr_free_low = at_ofs(i_bus.wr, i_bus.addr, OFS_FREE_LOW);
   wire wr_free_high = at_ofs(i_bus.wr, i_bus.addr, OFS_FREE_HIGH);
   wire rd_free_low = at_ofs(i_bus.rd, i_bus.addr, OFS_FREE_LOW);
   wire rd_free_high = at_ofs(i_bus.rd, i_bus.addr, OFS_FREE_HIGH);
   wire rd_ivl_low = at_ofs(i_bus.rd, i_bus.addr, OFS_IVL_CNT_LOW);
   wire wr_rld_low = at_ofs(i_bus.wr, i_bus.addr, OFS_IVL_RLD_LOW);
   wire wr_rld_high = at_ofs(i_bus.wr, i_bus.addr, OFS_IVL_RLD_HIGH);
   wire rd_rld_high = at_ofs(i_bus.rd, i_bus.addr, OFS_IVL_RLD_HIGH);
   wire wr_posted_one = at_ofs(i_bus.wr, i_bus.addr, OFS_POSTED_ONE);
   wire wr_posted_two = at_ofs(i_bus.wr, i_bus.addr, OFS_POSTED_TWO);
   wire rd_posted_one = at_ofs(i_bus.rd, i_bus.addr, OFS_POSTED_ONE);
   wire rd_posted_two = at_ofs(i_bus.rd, i_bus.addr, OFS_POSTED_TWO);
   wire rd_status = at_ofs(i_bus.rd, i_bus.addr, OFS_IRQ_STATUS);
   wire wr_enable = at_ofs(i_bus.wr, i_bus.addr, OFS_IRQ_ENABLE);
   wire wr_clear = at_ofs(i_bus.wr, i_bus.addr, OFS_IRQ_CLEAR);
   wire wr_ctrl = at_ofs(i_bus.wr, i_bus.addr, OFS_TIMER_CTRL);

   // Source edge and microsecond pacing
   wire src_tick = src_sync_ff && !src_last_ff && ctrl_ff[CTRL_RUN];
   wire [2:0] ticks_per_us = ctrl_ff[CTRL_SRC_6MHZ] ? SRC_6MHZ_TICKS_PER_US
                                                     : SRC_4MHZ_TICKS_PER_US;
   wire us_tick = src_tick && us_div_ff == ticks_per_us - 3'h1;
   wire ms_evt = us_tick && us_cnt_ff == MS_EVENT_LAST_US;
   wire wrap_evt = src_tick && !wr_free_high && free_cnt_ff == FREE_MAX;
   wire ivl_zero = ivl_cnt_ff == 12'h000;
   wire ivl_evt = us_tick && ivl_zero;

   // Events and clears, set wins over clear
   wire [NUM_EV-1:0] set_ev = {wrap_evt, ms_evt, ivl_evt};
   wire [NUM_EV-1:0] clr_posted = {
      wr_posted_two && !i_bus.wdata[BIT_POSTED_WRAP],
      wr_posted_one && !i_bus.wdata[BIT_POSTED_MS],
      wr_posted_one && !i_bus.wdata[BIT_POSTED_IVL]};
   wire [NUM_EV-1:0] clr_reg = wr_clear ? i_bus.wdata[NUM_EV-1:0] : '0;
   wire [NUM_EV-1:0] nxt_flags = set_ev | (flags_ff & ~(clr_posted | clr_reg));
   wire [NUM_EV-1:0] pend = flags_ff & en_ff;

   // Read mux
   logic [7:0] nxt_rdata;
   always_comb begin
      case (i_bus.addr)
         OFS_FREE_LOW: nxt_rdata = free_cnt_ff[7:0];
         OFS_FREE_HIGH: nxt_rdata = free_hold_ff;
         OFS_IVL_CNT_LOW: nxt_rdata = ivl_cnt_ff[7:0];
         OFS_IVL_CNT_HIGH: nxt_rdata = {4'h0, ivl_hold_ff};
         OFS_IVL_RLD_LOW: nxt_rdata = ivl_rld_ff[7:0];
         OFS_IVL_RLD_HIGH: nxt_rdata = {4'h0, ivl_rld_ff[11:8]};
         OFS_POSTED_ONE: nxt_rdata = (8'(flags_ff[EV_IVL]) << BIT_POSTED_IVL)
                                     | (8'(flags_ff[EV_MS]) << BIT_POSTED_MS);
         OFS_POSTED_TWO: nxt_rdata = 8'(flags_ff[EV_WRAP]) << BIT_POSTED_WRAP;
         OFS_IRQ_ENABLE: nxt_rdata = {5'h00, en_ff};
         OFS_IRQ_STATUS: nxt_rdata = {5'h00, flags_ff};
         OFS_TIMER_CTRL: nxt_rdata = {6'h00, ctrl_ff};
         default: nxt_rdata = RST_BYTE;
      endcase
      if (!i_bus.rd) begin
         nxt_rdata = RST_BYTE;
      end
   end

   // Highest priority pending source: 1 ms, then interval, then wrap
   irq_req_s nxt_irq_req;
   always_comb begin
      nxt_irq_req = '0;
      if (pend[EV_MS]) begin
         nxt_irq_req = '{valid: 1'b1, prio: PRIO_MS, vector: VEC_MS};
      end else if (pend[EV_IVL]) begin
         nxt_irq_req = '{valid: 1'b1, prio: PRIO_IVL, vector: VEC_IVL};
      end else if (pend[EV_WRAP]) begin
         nxt_irq_req = '{valid: 1'b1, prio: PRIO_WRAP, vector: VEC_WRAP};
      end
   end

   // Source synchroniser
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         src_meta_ff <= 1'b0;
         src_sync_ff <= 1'b0;
         src_last_ff <= 1'b0;
      end else begin
         src_meta_ff <= i_tmr_src;
         src_sync_ff <= src_meta_ff;
         src_last_ff <= src_sync_ff;
      end
   end

   // Microsecond divider and 1024 us counter
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         us_div_ff <= 3'h0;
         us_cnt_ff <= 10'h000;
      end else if (us_tick) begin
         us_div_ff <= 3'h0;
         us_cnt_ff <= us_cnt_ff + 10'h001;
      end else if (src_tick) begin
         us_div_ff <= us_div_ff + 3'h1;
      end
   end

   // Free-running counter with latched read and staged write
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         free_cnt_ff <= 16'h0000;
         free_hold_ff <= RST_BYTE;
         free_wlow_ff <= RST_BYTE;
      end else begin
         if (wr_free_high) begin
            free_cnt_ff <= {i_bus.wdata, free_wlow_ff};
         end else if (src_tick) begin
            free_cnt_ff <= free_cnt_ff + 16'h0001;
         end
         if (wr_free_low) begin
            free_wlow_ff <= i_bus.wdata;
         end
         if (rd_free_low) begin
            free_hold_ff <= free_cnt_ff[15:8];
         end
      end
   end

   // Interval timer, reload and latched read
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ivl_cnt_ff <= 12'h000;
         ivl_hold_ff <= 4'h0;
         ivl_rld_ff <= 12'h000;
         ivl_wlow_ff <= RST_BYTE;
      end else begin
         if (us_tick) begin
            ivl_cnt_ff <= ivl_zero ? ivl_rld_ff : ivl_cnt_ff - 12'h001;
         end
         if (rd_ivl_low) begin
            ivl_hold_ff <= ivl_cnt_ff[11:8];
         end
         if (wr_rld_low) begin
            ivl_wlow_ff <= i_bus.wdata;
         end
         if (wr_rld_high) begin
            ivl_rld_ff <= {i_bus.wdata[3:0], ivl_wlow_ff};
         end
      end
   end

   // Control, flags, read data and interrupt request
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         flags_ff <= '0;
         en_ff <= '0;
         ctrl_ff <= RST_CTRL;
         rdata_ff <= RST_BYTE;
         irq_req_ff <= '0;
      end else begin
         flags_ff <= nxt_flags;
         if (wr_enable) begin
            en_ff <= i_bus.wdata[NUM_EV-1:0];
         end
         if (wr_ctrl) begin
            ctrl_ff <= i_bus.wdata[1:0];
         end
         rdata_ff <= nxt_rdata;
         irq_req_ff <= nxt_irq_req;
      end
   end

   assign o_rdata = rdata_ff;
   assign o_irq = irq_req_ff.valid;
   assign o_irq_req = irq_req_ff;

   // Checks
   a_tick_from_pin: assert property (@(posedge i_clk) disable iff (!i_rstn)
      src_tick |-> $past(src_meta_ff) && !src_last_ff)
      else $error("tick without synchronised source edge");
   a_free_counts_up: assert property (@(posedge i_clk) disable iff (!i_rstn)
      src_tick && !wr_free_high |=> free_cnt_ff == 16'($past(free_cnt_ff) + 16'h0001))
      else $error("free counter did not advance");
   a_low_read_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_free_low |=> free_hold_ff == $past(free_cnt_ff[15:8])
                      && o_rdata == $past(free_cnt_ff[7:0]))
      else $error("free counter read not atomic");
   a_high_write_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_free_high |=> free_cnt_ff == {$past(i_bus.wdata), $past(free_wlow_ff)})
      else $error("free counter load wrong");
   a_ms_period_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
      us_tick && us_cnt_ff == 10'h3FF |=> flags_ff[EV_MS] && us_cnt_ff == 10'h000)
      else $error("1024 us event not posted");
   a_wrap_posts: assert property (@(posedge i_clk) disable iff (!i_rstn)
      src_tick && !wr_free_high && free_cnt_ff == 16'hFFFF
      |=> flags_ff[EV_WRAP] && free_cnt_ff == 16'h0000)
      else $error("wrap not posted");
   a_ivl_high_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_bus.rd && i_bus.addr == OFS_IVL_CNT_HIGH |=> o_rdata == {4'h0, $past(ivl_hold_ff)})
      else $error("interval high read wrong");
   a_ivl_reload: assert property (@(posedge i_clk) disable iff (!i_rstn)
      us_tick && ivl_zero |=> ivl_cnt_ff == $past(ivl_rld_ff) && flags_ff[EV_IVL])
      else $error("interval reload missed");
   a_rld_commit: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_rld_high |=> ivl_rld_ff == {$past(i_bus.wdata[3:0]), $past(ivl_wlow_ff)})
      else $error("reload commit wrong");
   a_ivl_vector: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_irq_req.prio == 5'h0E |-> o_irq_req.vector == 8'h38 && o_irq_req.valid)
      else $error("interval vector wrong");
   a_wrap_vector: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_irq_req.prio == 5'h11 |-> o_irq_req.vector == 8'h44 && o_irq_req.valid)
      else $error("wrap vector wrong");
   a_ms_vector: assert property (@(posedge i_clk) disable iff (!i_rstn)
      pend[EV_MS] |=> o_irq_req.prio == 5'h0D && o_irq_req.vector == 8'h34)
      else $error("1 ms vector wrong");
   a_posted_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_posted_one && !i_bus.wdata[6] && !ivl_evt |=> !flags_ff[EV_IVL])
      else $error("posted flag not cleared");
   // Counting, latching and staging
   a_stopped_no_tick: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !ctrl_ff[CTRL_RUN]
      |-> !src_tick)
      else $error("tick while stopped");
   a_free_holds: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !src_tick && !wr_free_high
      |=> $stable(free_cnt_ff))
      else $error("free counter moved without tick");
   a_high_read_held: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_free_high
      |=> o_rdata == $past(free_hold_ff))
      else $error("free high read not from hold");
   a_low_stage: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_free_low
      |=> free_wlow_ff == $past(i_bus.wdata))
      else $error("free low byte not staged");
   a_us_restart: assert property (@(posedge i_clk) disable iff (!i_rstn)
      us_tick
      |=> us_div_ff == 3'h0)
      else $error("microsecond divider not restarted");
   a_ms_only_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
      $rose(flags_ff[EV_MS])
      |-> $past(ms_evt))
      else $error("1 ms flag without event");
   a_wrap_only_max: assert property (@(posedge i_clk) disable iff (!i_rstn)
      $rose(flags_ff[EV_WRAP])
      |-> $past(wrap_evt))
      else $error("wrap flag without overflow");
   a_wrap_load_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_free_high
      |=> !$rose(flags_ff[EV_WRAP]))
      else $error("wrap raised by a load");
   a_ivl_low_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_ivl_low
      |=> ivl_hold_ff == $past(ivl_cnt_ff[11:8])
          && o_rdata == $past(ivl_cnt_ff[7:0]))
      else $error("interval read not atomic");
   a_ivl_counts_down: assert property (@(posedge i_clk) disable iff (!i_rstn)
      us_tick && !ivl_zero
      |=> ivl_cnt_ff == 12'($past(ivl_cnt_ff) - 12'h001))
      else $error("interval did not count down");
   a_ivl_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !us_tick
      |=> $stable(ivl_cnt_ff))
      else $error("interval moved between microseconds");
   a_ivl_only_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
      $rose(flags_ff[EV_IVL])
      |-> $past(ivl_evt))
      else $error("interval flag without expiry");
   a_rld_stage: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_rld_low
      |=> ivl_wlow_ff == $past(i_bus.wdata) && $stable(ivl_rld_ff))
      else $error("reload low byte not staged");
   a_rld_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_rld_high
      |=> o_rdata == {4'h0, $past(ivl_rld_ff[11:8])})
      else $error("reload high read wrong");
   // Flags, reads and interrupt line
   a_set_beats_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
      |set_ev
      |=> (flags_ff & $past(set_ev)) == $past(set_ev))
      else $error("event lost to a clear");
   a_ms_posted_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_posted_one && !i_bus.wdata[BIT_POSTED_MS] && !ms_evt
      |=> !flags_ff[EV_MS])
      else $error("1 ms flag not cleared");
   a_wrap_posted_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_posted_two && !i_bus.wdata[BIT_POSTED_WRAP] && !wrap_evt
      |=> !flags_ff[EV_WRAP])
      else $error("wrap flag not cleared");
   a_clear_reg: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_clear && i_bus.wdata[EV_WRAP] && !wrap_evt
      |=> !flags_ff[EV_WRAP])
      else $error("clear register missed wrap");
   a_posted_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_posted_one
      |=> o_rdata[BIT_POSTED_IVL] == $past(flags_ff[EV_IVL])
          && o_rdata[BIT_POSTED_MS] == $past(flags_ff[EV_MS]))
      else $error("posted flags one read wrong");
   a_posted_two_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_posted_two
      |=> o_rdata == 8'($past(flags_ff[EV_WRAP])) << BIT_POSTED_WRAP)
      else $error("posted flags two read wrong");
   a_status_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rd_status
      |=> o_rdata == {5'h00, $past(flags_ff)})
      else $error("status read wrong");
   a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rstn)
      1'b1
      |-> o_irq == $past(|pend))
      else $error("interrupt line does not follow pending");
   a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !i_bus.rd
      |=> o_rdata == 8'h00)
      else $error("read data outside read cycle");
   a_en_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_enable
      |=> en_ff == $past(i_bus.wdata[NUM_EV-1:0]))
      else $error("enable write lost");
   c_wrap_seen: cover property (@(posedge i_clk) disable iff (!i_rstn) wrap_evt);
   c_ms_fire: cover property (@(posedge i_clk) disable iff (!i_rstn) ms_evt ##2 o_irq);
   c_ivl_fire: cover property (@(posedge i_clk) disable iff (!i_rstn) ivl_evt ##1 o_irq);
   c_atomic_read: cover property (@(posedge i_clk) disable iff (!i_rstn)
      rd_free_low ##[1:4] (i_bus.rd && i_bus.addr == OFS_FREE_HIGH));
   c_set_and_clear: cover property (@(posedge i_clk) disable iff (!i_rstn)
      ivl_evt && wr_posted_one);
endmodule // free_running_and_interval_timer

/* File: design/frit_pkg.sv */
// Package for the free-running and interval timer block.
// Assumes an 8-bit register port and a timer source pin of 4 or 6 MHz.
package frit_pkg;
   // Register offsets
   localparam logic [7:0] OFS_FREE_LOW = 8'h20;
   localparam logic [7:0] OFS_FREE_HIGH = 8'h21;
   localparam logic [7:0] OFS_IVL_CNT_LOW = 8'h26;
   localparam logic [7:0] OFS_IVL_CNT_HIGH = 8'h27;
   localparam logic [7:0] OFS_IVL_RLD_LOW = 8'h28;
   localparam logic [7:0] OFS_IVL_RLD_HIGH = 8'h29;
   localparam logic [7:0] OFS_POSTED_ONE = 8'hDB;
   localparam logic [7:0] OFS_POSTED_TWO = 8'hDC;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'hE0;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'hE1;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'hE2;
   localparam logic [7:0] OFS_TIMER_CTRL = 8'hE3;
   // Field positions in posted flag registers
   localparam int BIT_POSTED_IVL = 6;
   localparam int BIT_POSTED_MS = 5;
   localparam int BIT_POSTED_WRAP = 1;
   // Field positions in enable, clear and status registers
   localparam int EV_IVL = 0;
   localparam int EV_MS = 1;
   localparam int EV_WRAP = 2;
   localparam int NUM_EV = 3;
   // Field positions in timer control register
   localparam int CTRL_SRC_6MHZ = 0;
   localparam int CTRL_RUN = 1;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_CTRL = 2'h2;
   // Source rates and periods
   localparam logic [2:0] SRC_4MHZ_TICKS_PER_US = 3'h4;
   localparam logic [2:0] SRC_6MHZ_TICKS_PER_US = 3'h6;
   localparam int MS_EVENT_TIME_US = 1024;
   localparam int US_TICK_TIME_US = 1;
   localparam logic [9:0] MS_EVENT_LAST_US = 10'(MS_EVENT_TIME_US / US_TICK_TIME_US - 1);
   localparam logic [15:0] FREE_MAX = 16'hFFFF;
   // Interrupt priorities and vectors
   localparam logic [4:0] PRIO_MS = 5'h0D;
   localparam logic [4:0] PRIO_IVL = 5'h0E;
   localparam logic [4:0] PRIO_WRAP = 5'h11;
   localparam logic [7:0] VEC_MS = 8'h34;
   localparam logic [7:0] VEC_IVL = 8'h38;
   localparam logic [7:0] VEC_WRAP = 8'h44;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic valid;
      logic [4:0] prio;
      logic [7:0] vector;
   } irq_req_s;
endpackage

/* File: dv/free_running_and_interval_timer_bench.sv */
// Self-checking bench for the timer block.
// Assumes only the block's ports; the bench drives all of them itself.
module free_running_and_interval_timer_bench import frit_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_tmr_src = 1'b0;
   bus_req_s i_bus = '0;
   logic [7:0] o_rdata;
   logic o_irq;
   irq_req_s o_irq_req;
   logic tick_en = 1'b0;
   logic [2:0] ph = 3'h0;
   logic rd_seen = 1'b0;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   logic [7:0] lo;
   logic [7:0] hi;
   int n_ticks = 0;
   int n_errors = 0;
   int num_checks = 0;
   int t0 = 0;
   logic [7:0] rst_a [12] = '{OFS_FREE_LOW, OFS_FREE_HIGH, OFS_IVL_CNT_LOW, OFS_IVL_CNT_HIGH,
      OFS_IVL_RLD_LOW, OFS_IVL_RLD_HIGH, OFS_POSTED_ONE, OFS_POSTED_TWO, OFS_IRQ_ENABLE,
      OFS_IRQ_STATUS, OFS_TIMER_CTRL, 8'h55};

   free_running_and_interval_timer i_free_running_and_interval_timer (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_tmr_src(i_tmr_src), .i_bus(i_bus),
      .o_rdata(o_rdata), .o_irq(o_irq), .o_irq_req(o_irq_req));

   always #12.5 i_clk = ~i_clk;

   // Source pin: one rising edge every 8 clocks while enabled
   always @(posedge i_clk) begin
      if (tick_en) begin
         ph <= ph + 3'h1;
         if (ph == 3'h7) begin
            i_tmr_src <= 1'b1;
            n_ticks <= n_ticks + 1;
         end else if (ph == 3'h3) begin
            i_tmr_src <= 1'b0;
         end
      end
   end

   task automatic fail(input string m);
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
   endtask

   task automatic cmp(input logic [13:0] got, input logic [13:0] want, input string m);
      num_checks++;
      if (got !== want) fail(m);
   endtask

   // Read data checked in the one cycle it stands
   always @(posedge i_clk) begin
      rd_seen <= i_bus.rd;
      if (rd_seen) begin
         if (exp_q.size() == 0) begin
            fail("read data with nothing expected");
         end else begin
            e = exp_q.pop_front();
            num_checks++;
            if ((o_rdata & e[7:0]) !== e[15:8]) fail("read data");
         end
      end
   end

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clk);
      i_bus <= '0;
      @(posedge i_clk);
   endtask

   task automatic bus_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m = 8'hFF);
      exp_q.push_back({d & m, m});
      i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_clk);
      i_bus <= '0;
      @(posedge i_clk);
   endtask

   task automatic wait_irq(input logic lvl, input int lim);
      int k;
      k = 0;
      while (o_irq !== lvl && k < lim) begin
         @(posedge i_clk);
         k++;
      end
      if (o_irq !== lvl) fail("interrupt line wait ran out");
   endtask

   task automatic ticks(input int n);
      int t;
      t = n_ticks + n;
      tick_en <= 1'b1;
      while (n_ticks != t) @(posedge i_clk);
      tick_en <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask

   task automatic close_out();
      $display("checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge i_clk);
      fail("watchdog ran out");
      close_out();
   end

   initial begin
      void'($urandom(7));
      repeat (4) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      cmp(14'(o_irq), 14'h0, "irq after reset");
      cmp(o_irq_req, 14'h0, "request after reset");
      foreach (rst_a[k]) bus_rd(rst_a[k], rst_a[k] == OFS_TIMER_CTRL ? {6'h00, RST_CTRL} : RST_BYTE);
      bus_wr(OFS_IVL_CNT_LOW, 8'hFF);
      bus_rd(OFS_IVL_CNT_LOW, 8'h00);
      // Periodic event counted in source ticks from reset
      bus_wr(OFS_IRQ_ENABLE, 8'h02);
      tick_en <= 1'b1;
      wait_irq(1'b1, 40000);
      t0 = n_ticks;
      tick_en <= 1'b0;
      cmp(14'(t0), 14'(MS_EVENT_TIME_US * int'(SRC_4MHZ_TICKS_PER_US)), "1 ms spacing");
      cmp(o_irq_req, {1'b1, PRIO_MS, VEC_MS}, "1 ms request");
      bus_rd(OFS_POSTED_ONE, 8'h20, 8'h20);
      bus_wr(OFS_IRQ_ENABLE, 8'h00);
      repeat (2) @(posedge i_clk);
      cmp(14'(o_irq), 14'h0, "masked irq");
      bus_rd(OFS_IRQ_STATUS, 8'h02, 8'h02);
      bus_wr(OFS_IRQ_CLEAR, 8'h07);
      // Reload 2, upper bits above the nibble dropped
      bus_wr(OFS_IVL_RLD_LOW, 8'h02);
      bus_wr(OFS_IVL_RLD_HIGH, 8'hF0);
      bus_rd(OFS_IVL_RLD_LOW, 8'h02);
      bus_rd(OFS_IVL_RLD_HIGH, 8'h00);
      bus_wr(OFS_IRQ_ENABLE, 8'h01);
      for (int m = 0; m < 2; m++) begin
         bus_wr(OFS_TIMER_CTRL, 8'(2 + m));
         tick_en <= 1'b1;
         for (int j = 0; j < 3; j++) begin
            bus_wr(OFS_POSTED_ONE, 8'h00);
            wait_irq(1'b0, 20);
            wait_irq(1'b1, 400);
            if (j == 2) cmp(14'(n_ticks - t0), 14'(3 * (m ? 6 : 4)), "interval period");
            if (j == 2) cmp(o_irq_req, {1'b1, PRIO_IVL, VEC_IVL}, "interval request");
            t0 = n_ticks;
         end
      end
      tick_en <= 1'b0;
      bus_wr(OFS_IRQ_ENABLE, 8'h00);
      bus_wr(OFS_TIMER_CTRL, 8'h02);
      bus_rd(OFS_IVL_CNT_LOW, 8'h00, 8'hFC);
      bus_rd(OFS_IVL_CNT_HIGH, 8'h00);
      lo = 8'($urandom);
      hi = 8'($urandom);
      bus_wr(OFS_FREE_LOW, lo);
      bus_wr(OFS_FREE_HIGH, hi);
      bus_rd(OFS_FREE_LOW, lo);
      bus_rd(OFS_FREE_HIGH, hi);
      bus_wr(OFS_FREE_LOW, 8'hFD);
      bus_wr(OFS_FREE_HIGH, 8'hFF);
      bus_wr(OFS_IRQ_CLEAR, 8'h07);
      bus_wr(OFS_POSTED_TWO, 8'h00);
      bus_wr(OFS_IRQ_ENABLE, 8'h04);
      ticks(2);
      cmp(14'(o_irq), 14'h0, "wrap too early");
      ticks(1);
      cmp(14'(o_irq), 14'h1, "wrap irq");
      cmp(o_irq_req, {1'b1, PRIO_WRAP, VEC_WRAP}, "wrap request");
      bus_rd(OFS_POSTED_TWO, 8'h02);
      bus_rd(OFS_IRQ_STATUS, 8'h04, 8'h04);
      // High byte held from the low read across a tick
      bus_wr(OFS_FREE_LOW, 8'hFF);
      bus_wr(OFS_FREE_HIGH, 8'h12);
      bus_rd(OFS_FREE_LOW, 8'hFF);
      ticks(1);
      bus_rd(OFS_FREE_HIGH, 8'h12);
      bus_rd(OFS_FREE_LOW, 8'h00);
      bus_rd(OFS_FREE_HIGH, 8'h13);
      // Run bit low: source edges no longer count
      bus_wr(OFS_TIMER_CTRL, 8'h00);
      ticks(2);
      bus_rd(OFS_FREE_LOW, 8'h00);
      bus_rd(OFS_FREE_HIGH, 8'h13);
      bus_wr(OFS_POSTED_TWO, 8'h00);
      repeat (2) @(posedge i_clk);
      cmp(14'(o_irq), 14'h0, "wrap cleared");
      close_out();
   end
endmodule // free_running_and_interval_timer_bench
